// *** shared/sclkg_pkg.sv ***
/*
 * Constants, register map and carrier types of the sleep clock gating unit.
 * Assumes a single system clock and an 8-bit register port behind the CPU.
 */
// Notes on behaviour
// RULE1: Sleep starts on the sleep instruction only with sleep enable set.
// RULE2: Mode 010 is power-down: all generated clocks and the oscillator stop.
// RULE3: Mode 110 with a crystal is standby: power-down with oscillator on.
// RULE4: A wake-up from standby resumes operation six clock cycles later.
// RULE5: Mode 111 with a crystal is extended standby, identical to standby.
// RULE6: Core and flash clocks stop in sleep; other clocks depend on mode.
// RULE7: Deep modes wake only on external, pin change, match, watchdog, USB.
// RULE8: Bus supply change and bus wake interrupts wake from every sleep mode.
// RULE9: A set stop bit halts a peripheral clock and blocks register access.
// RULE10: A cleared stop bit restarts the clock; the state is kept.
// RULE11: Peripheral stop bits matter only in active and idle operation; here the converter stop bit also acts in ADC quiet.
// RULE12: Stop register 0 bit 7 halts the two-wire clock.
// RULE13: Stop register 0 bit 6 halts timer two only in synchronous mode.
// RULE14: Stop register 0 bits 5 and 3 halt timers zero and one.
// RULE15: Stop register 0 bit 2 halts the serial peripheral clock.
// RULE16: Stop register 0 bit 0 halts the converter; comparator loses its mux.
// RULE17: Reserved stop register bits always read as zero.
// RULE18: Stop register 1 bit 7 halts the USB controller clock.
// RULE19: Stop register 1 bits 4 and 3 halt timers four and three.
// RULE20: Stop register 1 bit 0 halts serial port one.
// RULE21: Converter stays on in sleep; after off and on, next is extended.
// RULE22: Both stop registers reset to zero so every peripheral clock runs.
package sclkg_pkg;

  // ****************************************************************
  // Register port and map
  // ****************************************************************
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  localparam logic [3:0]  OFS_SLEEP_CTRL  = 4'h0;
  localparam logic [3:0]  OFS_STOP0       = 4'h1;
  localparam logic [3:0]  OFS_STOP1       = 4'h2;
  localparam logic [3:0]  OFS_STATUS      = 4'h3;
  localparam logic [7:0]  STOP0_RESET     = 8'h00;
  localparam logic [7:0]  STOP1_RESET     = 8'h00;
  localparam logic [7:0]  STOP0_WR_MASK   = 8'hED;
  localparam logic [7:0]  STOP1_WR_MASK   = 8'h99;
  localparam logic [7:0]  CTRL_WR_MASK    = 8'h0F;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;

  // Field positions.
  localparam int          SE_BIT          = 0;
  localparam int          MODE_LSB        = 1;
  localparam int          MODE_W          = 3;
  localparam int          ST_SLEEPING     = 0;
  localparam int          ST_MODE_LSB     = 1;
  localparam int          ST_WAKING       = 4;
  localparam int          ST_ADC_EXT      = 5;
  localparam int          ST_CRYSTAL      = 6;
  localparam int          B0_TWI          = 7;
  localparam int          B0_TIM2         = 6;
  localparam int          B0_TIM0         = 5;
  localparam int          B0_RES4         = 4;
  localparam int          B0_TIM1         = 3;
  localparam int          B0_SPI          = 2;
  localparam int          B0_RES1         = 1;
  localparam int          B0_ADC          = 0;
  localparam int          B1_USB          = 7;
  localparam int          B1_TIM4         = 4;
  localparam int          B1_TIM3         = 3;
  localparam int          B1_USART1       = 0;

  // Sleep mode codes.
  localparam logic [2:0]  MODE_IDLE       = 3'h0;
  localparam logic [2:0]  MODE_ADC_QUIET  = 3'h1;
  localparam logic [2:0]  MODE_PWR_DOWN   = 3'h2;
  localparam logic [2:0]  MODE_PWR_SAVE   = 3'h3;
  localparam logic [2:0]  MODE_STANDBY    = 3'h6;
  localparam logic [2:0]  MODE_EXT_STBY   = 3'h7;

  // Wake-up delays in clock cycles.
  localparam int          STANDBY_WAKE_CYC = 6;
  localparam int          QUICK_WAKE_CYC   = 1;
  localparam int          PD_WAKE_CYC_DEF  = 16;
  localparam int          WAKE_CNT_W       = 8;

  // Peripheral indices of the gate array.
  localparam int          P_TWI = 0;
  localparam int          P_TIM2 = 1;
  localparam int          P_TIM0 = 2;
  localparam int          P_TIM1 = 3;
  localparam int          P_SPI = 4;
  localparam int          P_ADC = 5;
  localparam int          P_USB = 6;
  localparam int          P_TIM4 = 7;
  localparam int          P_TIM3 = 8;
  localparam int          P_USART1 = 9;
  localparam int          PERIPH_N = 10;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } sclkg_bus_t;

  typedef struct packed {
    logic core_clock;
    logic program_memory_clock;
    logic peripheral_io_clock;
    logic converter_clock;
    logic main_osc;
  } sclkg_domains_t;

  typedef struct packed {
    logic [3:0] ext_irq_low_group;
    logic       ext_irq_high_level;
    logic       ext_irq_high_edge;
    logic       pin_change;
    logic       two_wire_addr_match;
    logic       watchdog_irq;
    logic       bus_supply_change_irq;
    logic       bus_wake_irq;
    logic       adc_done;
    logic       spm_ready;
    logic       two_wire_irq;
    logic       usb_sync_irq;
    logic       other_io_irq;
  } sclkg_wake_t;

endpackage

// *** src/sclkg_periph_gate.sv ***
/*
 * One peripheral clock gate: a registered run enable and access grant.
 * Assumes domain_run and stop are synchronous to clk.
 */
`timescale 1ns/10ps
module sclkg_periph_gate (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic clk_en,
  input  wire logic domain_run,
  input  wire logic stop,
  output logic      run,
  output logic      access_ok
);

  // ****************************************************************
  // Gate flops
  // ****************************************************************
  // The peripheral runs only while its domain runs and it is not stopped.
  // Its own flops are untouched, so a restart resumes where it halted.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run <= 1'b1;
    end else if (clk_en) begin
      run <= domain_run & ~stop; // RULE9 RULE10
    end
  end

  // Register access is refused while the peripheral is stopped.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      access_ok <= 1'b1;
    end else if (clk_en) begin
      access_ok <= ~stop; // RULE9
    end
  end

endmodule

// *** src/sclkg_unit.sv ***
/*
 * Sleep clock gating unit: sleep state machine, clock domain enables,
 * wake-up filtering and the two peripheral clock stop registers.
 * Assumes all inputs synchronous to clk and a CPU driving the register port.
 */
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module sclkg_unit #(
  parameter int PD_WAKE_CYC = sclkg_pkg::PD_WAKE_CYC_DEF
) (
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  input  wire logic                             clk_en,
  input  wire sclkg_pkg::sclkg_bus_t            bus,
  output logic [sclkg_pkg::DATA_W-1:0]          rdata,
  input  wire logic                             sleep_instr,
  input  wire logic                             crystal_option,
  input  wire logic                             timer_two_async_select,
  input  wire logic                             adc_enable,
  input  wire logic                             adc_conv_start,
  input  wire sclkg_pkg::sclkg_wake_t           wake,
  output sclkg_pkg::sclkg_domains_t             domains,
  output logic [sclkg_pkg::PERIPH_N-1:0]        periph_run,
  output logic [sclkg_pkg::PERIPH_N-1:0]        periph_access_ok,
  output logic                                  cpu_sleeping,
  output logic                                  wake_done,
  output logic                                  adc_extended_next,
  output logic                                  comparator_mux_ok
);
  import sclkg_pkg::*;

  typedef enum logic [1:0] {S_ACTIVE, S_SLEEP, S_WAKE} sclkg_state_t;

  localparam logic [WAKE_CNT_W-1:0] SB_LOAD =
    WAKE_CNT_W'(STANDBY_WAKE_CYC - 1);
  localparam logic [WAKE_CNT_W-1:0] PD_LOAD =
    WAKE_CNT_W'(PD_WAKE_CYC - 1);
  localparam logic [WAKE_CNT_W-1:0] CNT_ONE = WAKE_CNT_W'(1);

  sclkg_state_t          state_reg;
  sclkg_state_t          state_next;
  logic [7:0]            ctrl_reg;
  logic [7:0]            stop0_reg;
  logic [7:0]            stop1_reg;
  logic [WAKE_CNT_W-1:0] cnt_reg;
  logic [2:0]            mode_reg;
  logic [2:0]            mode_eff;
  logic                  adc_en_q_reg;
  logic [2:0]            mode_sel;
  logic                  mode_legal;
  logic                  sleep_go;
  logic                  deep_mode;
  logic                  standby_mode;
  logic                  deep_src;
  logic                  quiet_src;
  logic                  idle_src;
  logic                  wake_hit;
  logic                  quick_mode;
  logic                  adc_ext_set;
  logic [7:0]            status;
  sclkg_domains_t        dom_next;
  logic [PERIPH_N-1:0]   gate_stop;
  logic [PERIPH_N-1:0]   gate_domain;

  // ****************************************************************
  // Register port
  // ****************************************************************
  assign mode_sel = ctrl_reg[MODE_LSB +: MODE_W];

  // Software writes land in one cycle; reserved bits are never stored.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg  <= ZERO_BYTE;
      stop0_reg <= STOP0_RESET; // RULE22
      stop1_reg <= STOP1_RESET; // RULE22
    end else if (clk_en && bus.wr) begin
      unique case (bus.addr)
        OFS_SLEEP_CTRL: ctrl_reg  <= bus.wdata & CTRL_WR_MASK;
        OFS_STOP0:      stop0_reg <= bus.wdata & STOP0_WR_MASK; // RULE17
        OFS_STOP1:      stop1_reg <= bus.wdata & STOP1_WR_MASK; // RULE17
        default:        ctrl_reg  <= ctrl_reg;
      endcase
    end
  end

  // Status shows the block's own state for software.
  always_comb begin
    status = ZERO_BYTE;
    status[ST_SLEEPING] = (state_reg == S_SLEEP);
    status[ST_MODE_LSB +: MODE_W] = mode_reg;
    status[ST_WAKING] = (state_reg == S_WAKE);
    status[ST_ADC_EXT] = adc_extended_next;
    status[ST_CRYSTAL] = crystal_option;
  end

  // Read data stand in the cycle after the strobe only; unmapped reads 0.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= ZERO_BYTE;
    end else if (clk_en) begin
      rdata <= ZERO_BYTE;
      if (bus.rd) begin
        unique case (bus.addr)
          OFS_SLEEP_CTRL: rdata <= ctrl_reg;
          OFS_STOP0:      rdata <= stop0_reg; // RULE17
          OFS_STOP1:      rdata <= stop1_reg; // RULE17
          OFS_STATUS:     rdata <= status;
          default:        rdata <= ZERO_BYTE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Sleep state machine
  // ****************************************************************
  // Reserved codes 100 and 101 are refused, so the CPU keeps running.
  assign mode_legal = (mode_sel[2:1] != 2'b10);
  assign sleep_go = sleep_instr & ctrl_reg[SE_BIT] & mode_legal; // RULE1

  // At entry the latched mode still holds the previous sleep, so the
  // fresh field steers the first sleeping cycle's domains.
  assign mode_eff = (state_reg == S_ACTIVE) ? mode_sel : mode_reg;

  // Standby needs a crystal; without one the oscillator is not kept.
  assign standby_mode = crystal_option &&
    (mode_eff == MODE_STANDBY || mode_eff == MODE_EXT_STBY); // RULE3 RULE5
  assign deep_mode = (mode_reg != MODE_IDLE) && (mode_reg != MODE_ADC_QUIET);
  assign quick_mode = !deep_mode;

  // Wake filters widen from the deep modes up to idle.
  assign deep_src = (|wake.ext_irq_low_group) | wake.ext_irq_high_level |
    wake.pin_change | wake.two_wire_addr_match | wake.watchdog_irq |
    wake.bus_supply_change_irq | wake.bus_wake_irq; // RULE7 RULE8
  assign quiet_src = deep_src | wake.adc_done | wake.spm_ready |
    wake.two_wire_irq | wake.usb_sync_irq;
  assign idle_src = quiet_src | wake.ext_irq_high_edge | wake.other_io_irq;

  always_comb begin
    unique case (mode_reg)
      MODE_IDLE:      wake_hit = idle_src;
      MODE_ADC_QUIET: wake_hit = quiet_src;
      default:        wake_hit = deep_src; // RULE7
    endcase
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_ACTIVE: if (sleep_go) state_next = S_SLEEP; // RULE1
      S_SLEEP: begin
        if (wake_hit) begin
          state_next = quick_mode ? S_ACTIVE : S_WAKE;
        end
      end
      S_WAKE: if (cnt_reg == CNT_ONE) state_next = S_ACTIVE; // RULE4
      default: state_next = S_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= S_ACTIVE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Mode is latched at entry so a later write cannot reshape the sleep.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= MODE_IDLE;
    end else if (clk_en && state_reg == S_ACTIVE && sleep_go) begin
      mode_reg <= mode_sel;
    end
  end

  // Restart delay: six cycles in standby, the start-up count in the other deep modes.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
    end else if (clk_en) begin
      if (state_reg == S_SLEEP && wake_hit) begin
        cnt_reg <= standby_mode ? SB_LOAD : PD_LOAD; // RULE4
      end else if (state_reg == S_WAKE) begin
        cnt_reg <= cnt_reg - CNT_ONE;
      end
    end
  end

  // ****************************************************************
  // Clock domain enables
  // ****************************************************************
  always_comb begin
    dom_next = '0;
    unique case (state_next)
      S_ACTIVE: dom_next = '1;
      S_WAKE:   dom_next.main_osc = 1'b1;
      S_SLEEP: begin
        // Core and flash clocks stay off in every sleep mode.
        if (mode_eff == MODE_IDLE) begin
          dom_next.peripheral_io_clock = 1'b1; // RULE6
          dom_next.converter_clock = 1'b1;
          dom_next.main_osc = 1'b1;
        end else if (mode_eff == MODE_ADC_QUIET) begin
          dom_next.converter_clock = 1'b1; // RULE6
          dom_next.main_osc = 1'b1;
        end else begin
          dom_next.main_osc = standby_mode; // RULE2 RULE3 RULE5
        end
      end
      default: dom_next = '1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      domains <= '1;
    end else if (clk_en) begin
      domains <= dom_next;
    end
  end

  // A pulse marks the return to active operation.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_done    <= 1'b0;
      cpu_sleeping <= 1'b0;
    end else if (clk_en) begin
      wake_done    <= (state_reg != S_ACTIVE) && (state_next == S_ACTIVE);
      cpu_sleeping <= (state_next != S_ACTIVE);
    end
  end

  // ****************************************************************
  // Peripheral clock stops
  // ****************************************************************
  // Gating rides on the domain enable, so stop bits only add anything
  // while their domain runs: active and idle, plus ADC quiet for the converter.
  always_comb begin
    gate_stop = '0;
    gate_stop[P_TWI]  = stop0_reg[B0_TWI]; // RULE12
    gate_stop[P_TIM2] = stop0_reg[B0_TIM2] &
      ~timer_two_async_select; // RULE13
    gate_stop[P_TIM0] = stop0_reg[B0_TIM0]; // RULE14
    gate_stop[P_TIM1] = stop0_reg[B0_TIM1]; // RULE14
    gate_stop[P_SPI]  = stop0_reg[B0_SPI]; // RULE15
    gate_stop[P_ADC]  = stop0_reg[B0_ADC]; // RULE16
    gate_stop[P_USB]  = stop1_reg[B1_USB]; // RULE18
    gate_stop[P_TIM4] = stop1_reg[B1_TIM4]; // RULE19
    gate_stop[P_TIM3] = stop1_reg[B1_TIM3]; // RULE19
    gate_stop[P_USART1] = stop1_reg[B1_USART1]; // RULE20
    gate_domain = {PERIPH_N{dom_next.peripheral_io_clock}}; // RULE11
    gate_domain[P_ADC] = dom_next.converter_clock;
    // An asynchronous timer two runs from its own clock.
    gate_domain[P_TIM2] = dom_next.peripheral_io_clock |
      timer_two_async_select;
  end

  genvar gi;
  generate
    for (gi = 0; gi < PERIPH_N; gi++) begin : g_gate
      sclkg_periph_gate u_gate (
        .clk        (clk),
        .rst_b      (rst_b),
        .clk_en     (clk_en),
        .domain_run (gate_domain[gi]),
        .stop       (gate_stop[gi]),
        .run        (periph_run[gi]),
        .access_ok  (periph_access_ok[gi])
      );
    end
  endgenerate

  // The comparator loses the converter multiplexer while it is stopped.
  assign comparator_mux_ok = ~stop0_reg[B0_ADC]; // RULE16

  // ****************************************************************
  // Converter restart tracking
  // ****************************************************************
  // Sleep does not touch the enable; a fresh switch-on forces one long
  // conversion. The set beats a coincident conversion start.
  assign adc_ext_set = adc_enable & ~adc_en_q_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adc_en_q_reg      <= 1'b0;
      adc_extended_next <= 1'b1;
    end else if (clk_en) begin
      adc_en_q_reg <= adc_enable;
      if (adc_ext_set) begin
        adc_extended_next <= 1'b1; // RULE21
      end else if (adc_conv_start) begin
        adc_extended_next <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || !clk_en);

  sequence s_sb_wake;
    state_reg == S_SLEEP && standby_mode && wake_hit;
  endsequence
  sequence s_held_then_run;
    (state_reg != S_ACTIVE)[*5] ##1 (state_reg == S_ACTIVE);
  endsequence

  a_sleep_needs_enable: assert property ( // RULE1
    state_reg == S_ACTIVE && sleep_instr && !ctrl_reg[SE_BIT]
    |=> state_reg == S_ACTIVE && !cpu_sleeping)
    else $error("sleep entered without sleep enable");
  a_pd_all_off: assert property ( // RULE2
    state_reg == S_SLEEP && mode_reg == MODE_PWR_DOWN && !wake_hit
    |=> domains == '0)
    else $error("clock left running in power-down");
  a_standby_osc: assert property ( // RULE3
    state_reg == S_SLEEP && crystal_option && mode_reg == MODE_STANDBY
    && !wake_hit |=> domains.main_osc && !domains.peripheral_io_clock)
    else $error("standby domains wrong");
  a_standby_six: assert property ( // RULE4
    s_sb_wake |=> s_held_then_run)
    else $error("standby wake not six cycles");
  a_ext_stby_same: assert property ( // RULE5
    state_reg == S_SLEEP && crystal_option && mode_reg == MODE_EXT_STBY
    && !wake_hit |=> domains.main_osc && !domains.converter_clock)
    else $error("extended standby differs from standby");
  a_idle_domains: assert property ( // RULE6
    state_reg == S_SLEEP && mode_reg == MODE_IDLE && !wake_hit
    |=> !domains.core_clock && !domains.program_memory_clock
    && domains.peripheral_io_clock && domains.converter_clock)
    else $error("idle domains wrong");
  a_deep_wake_filter: assert property ( // RULE7
    state_reg == S_SLEEP && deep_mode && !deep_src |=> state_reg == S_SLEEP)
    else $error("deep sleep woken by a disallowed source");
  a_usb_async_wake: assert property ( // RULE8
    state_reg == S_SLEEP && wake.bus_wake_irq |=> state_reg != S_SLEEP)
    else $error("bus wake ignored");
  a_stop_blocks: assert property ( // RULE9
    bus.wr && bus.addr == OFS_STOP0 && bus.wdata[B0_TWI]
    |=> ##1 !periph_run[P_TWI] && !periph_access_ok[P_TWI])
    else $error("two-wire clock not stopped");
  a_sleep_gated: assert property ( // RULE11
    !domains.peripheral_io_clock && $past(!domains.peripheral_io_clock)
    |-> !periph_run[P_SPI] && !periph_run[P_USART1])
    else $error("peripheral clock runs with I/O clock off");
  a_reserved_zero: assert property ( // RULE17
    bus.rd && bus.addr == OFS_STOP1
    |=> rdata[6:5] == 2'b00 && rdata[2:1] == 2'b00)
    else $error("reserved stop bits read nonzero");
  a_adc_ext_next: assert property ( // RULE21
    adc_enable && !$past(adc_enable) |=> adc_extended_next)
    else $error("switch-on did not force extended conversion");

endmodule

// *** testbench/sclkg_periph_model.sv ***
/*
 * Far-side model: the two-wire module, ticking while its clock runs.
 * Assumes periph_run comes registered from the gating unit on clk.
 */
`timescale 1ns/10ps
module sclkg_periph_model (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic [sclkg_pkg::PERIPH_N-1:0] periph_run,
  output logic [7:0]                         twi_ticks
);
  import sclkg_pkg::*;
  // The count only moves with the clock, so a restart resumes from it.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      twi_ticks <= 8'h00;
    end else if (periph_run[P_TWI]) begin
      twi_ticks <= twi_ticks + 8'h01;
    end
  end
endmodule

// *** testbench/sclkg_unit_bench.sv ***
/*
 * Self-checking bench of the sleep clock gating unit.
 * Assumes the package constants and a short power-down wake of 3 cycles.
 */
`timescale 1ns/10ps
module sclkg_unit_bench;
  import sclkg_pkg::*;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
  n_mismatch++; $display("Error at %0t: got %0h want %0h", $time, a, e); \
  end end
  logic clk = 0, rst_b = 0, slp_in = 0, xtal = 0, as = 0, adc_en = 0;
  logic conv = 0, slp, wdone, ext_next, cmp_ok;
  sclkg_bus_t     bus = '0;
  sclkg_wake_t    wake = '0, w;
  sclkg_domains_t dom;
  logic [7:0]     rdata, ticks, t0, s0, s1;
  logic [9:0]     prun, pacc, er;
  int             n_mismatch = 0, n_compared = 0, cyc = 0;
  // A short wake count keeps the deep-sleep scenarios brief.
  sclkg_unit #(.PD_WAKE_CYC(3)) dut (.clk(clk), .rst_b(rst_b), .clk_en(1'b1),
    .bus(bus), .rdata(rdata), .sleep_instr(slp_in), .crystal_option(xtal),
    .timer_two_async_select(as), .adc_enable(adc_en), .adc_conv_start(conv),
    .wake(wake), .domains(dom), .periph_run(prun), .periph_access_ok(pacc),
    .cpu_sleeping(slp), .wake_done(wdone), .adc_extended_next(ext_next),
    .comparator_mux_ok(cmp_ok));
  sclkg_periph_model peri (.clk(clk), .rst_b(rst_b), .periph_run(prun),
    .twi_ticks(ticks));
  always #20 clk = ~clk;
  // A hang is cut short well beyond the few hundred cycles needed.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // ****************************************************************
  // Bus cycles and helpers
  // ****************************************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 `CHK(rdata, e)
  endtask
  task automatic pulse(input sclkg_wake_t v);
    @(posedge clk) wake <= v;
    @(posedge clk) wake <= '0;
  endtask
  // Enters a sleep state and checks the running domains.
  task automatic go(input logic [2:0] m, input logic [4:0] d);
    wr(OFS_SLEEP_CTRL, {4'h0, m, 1'b1});
    @(posedge clk) slp_in <= 1'b1;
    @(posedge clk) slp_in <= 1'b0;
    #1 `CHK(slp, 1'b1)
    `CHK(dom, d)
  endtask
  // Counts cycles from the one holding the wake event until the core runs.
  task automatic wait_wake(input int n);
    int k;
    k = 1;
    #1;
    while (slp === 1'b1 && k < 50) begin
      @(posedge clk) #1 k++;
    end
    `CHK(k, n)
    `CHK(wdone, 1'b1)
  endtask
  function automatic logic [9:0] exp_run(logic [7:0] a, b, logic t);
    return ~{b[0], b[3], b[4], b[7], a[0], a[2], a[3], a[5], a[6] & ~t, a[7]};
  endfunction
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'h29ec_9d9f));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd(OFS_STOP0, 8'h00);
    rd(OFS_STOP1, 8'h00);
    `CHK(ext_next, 1'b1)
    $display("reset test done");
    // All-ones first, then random stop patterns.
    for (int i = 0; i < 24; i++) begin
      s0 = i == 0 ? 8'hFF : 8'($urandom);
      s1 = i == 0 ? 8'hFF : 8'($urandom);
      as <= 1'($urandom);
      wr(OFS_STOP0, s0);
      wr(OFS_STOP1, s1);
      er = exp_run(s0, s1, as);
      @(posedge clk) #1 `CHK(prun[4:0], er[4:0])
      `CHK(prun[5], er[5])
      `CHK(prun[9:6], er[9:6])
      `CHK(pacc[P_TWI], ~s0[B0_TWI])
      `CHK(cmp_ok, ~s0[B0_ADC])
      rd(OFS_STOP0, s0 & STOP0_WR_MASK);
      rd(OFS_STOP1, s1 & STOP1_WR_MASK);
    end
    wr(OFS_STOP0, 8'h80);
    wr(OFS_STOP1, 8'h00);
    @(posedge clk) #1 t0 = ticks;
    repeat (5) @(posedge clk);
    #1 `CHK(ticks, t0)
    wr(OFS_STOP0, 8'h00);
    repeat (4) @(posedge clk);
    #1 `CHK(ticks, t0 + 8'h03)
    $display("stop register test done");
    xtal <= 1'b1;
    as <= 1'b0;
    w = '0;
    w.other_io_irq = 1'b1;
    go(MODE_IDLE, 5'b00111);
    pulse(w);
    wait_wake(1);
    go(MODE_ADC_QUIET, 5'b00011);
    w = '0;
    w.adc_done = 1'b1;
    pulse(w);
    wait_wake(1);
    go(MODE_STANDBY, 5'b00001);
    w = '0;
    w.watchdog_irq = 1'b1;
    pulse(w);
    wait_wake(STANDBY_WAKE_CYC);
    go(MODE_EXT_STBY, 5'b00001);
    w = '0;
    w.two_wire_addr_match = 1'b1;
    pulse(w);
    wait_wake(6);
    go(MODE_PWR_DOWN, 5'b00000);
    @(posedge clk) #1 `CHK(prun, 10'h000)
    w = '0;
    w.other_io_irq = 1'b1;
    w.ext_irq_high_edge = 1'b1;
    w.usb_sync_irq = 1'b1;
    pulse(w);
    repeat (5) @(posedge clk);
    #1 `CHK(slp, 1'b1)
    w = '0;
    w.bus_wake_irq = 1'b1;
    pulse(w);
    wait_wake(3);
    go(MODE_PWR_SAVE, 5'b00000);
    w = '0;
    w.bus_supply_change_irq = 1'b1;
    pulse(w);
    wait_wake(3);
    // Without the enable bit the sleep instruction must do nothing.
    wr(OFS_SLEEP_CTRL, 8'h00);
    @(posedge clk) slp_in <= 1'b1;
    @(posedge clk) slp_in <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK(slp, 1'b0)
    // Status: crystal set, extended flag set, last mode power-save latched.
    rd(OFS_STATUS, 8'h66);
    $display("sleep test done");
    @(posedge clk) conv <= 1'b1;
    @(posedge clk) conv <= 1'b0;
    #1 `CHK(ext_next, 1'b0)
    @(posedge clk) adc_en <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK(ext_next, 1'b1)
    $display("converter test done");
    finish_test();
  end
endmodule
